// >>> logic/off_diag_pkg.sv
/*
  Constants for the off-state fault diagnostic block: register map,
  field positions, reset values, timebase dividers and expiry counts.
  Assumes a 32-bit AXI4-Lite register bus and eight gate channels.
*/
`default_nettype none
package off_diag_pkg;
  localparam int unsigned CH_N = 8;
  // register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] DIAG_OFS = 8'h04;
  localparam logic [7:0] FAULT_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  // cfg fields
  localparam int unsigned CFG_TB_LSB = 0;
  localparam int unsigned CFG_MASK_SG_BIT = 2;
  localparam int unsigned CFG_MASK_OL_BIT = 3;
  localparam int unsigned CFG_MASK_OV_BIT = 4;
  localparam logic [4:0] CFG_RST = 5'h00;
  // diag / fault register fields
  localparam int unsigned TESTED_LSB = 0;
  localparam int unsigned SG_LSB = 8;
  localparam int unsigned OL_LSB = 16;
  // interrupt status bits
  localparam int unsigned IRQ_OV_BIT = 0;
  localparam int unsigned IRQ_SG_BIT = 1;
  localparam int unsigned IRQ_OL_BIT = 2;
  localparam int unsigned IRQ_TESTED_BIT = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // timebase selection
  localparam logic [1:0] TB_128A = 2'b00;
  localparam logic [1:0] TB_192 = 2'b01;
  localparam logic [1:0] TB_FAST = 2'b10;
  localparam logic [1:0] TB_256 = 2'b11;
  localparam logic [7:0] DIV_128_M1 = 8'h7F;
  localparam logic [7:0] DIV_192_M1 = 8'hBF;
  localparam logic [7:0] DIV_256_M1 = 8'hFF;
  // a timer expires on reaching this many ticks
  localparam logic [3:0] EXP_LONG = 4'hB;
  localparam logic [3:0] EXP_SHORT = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage
`default_nettype wire

// >>> logic/off_state_diag.sv
/*
  Off-state diagnostics for eight gate-drive channels: tested timers,
  fault filters, latched fault flags, overvoltage shutdown, open-drain
  fault pin, interrupt and an AXI4-Lite register slave.
  Assumes comparator and battery inputs are asynchronous pins and that
  gate_cmd_in comes from the current controller on clk_in.
*/
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module off_state_diag #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] gate_cmd_in,
  input wire logic [7:0] open_load_raw_in,
  input wire logic [7:0] ground_short_raw_in,
  input wire logic battery_sense_in,
  output logic [7:0] gate_drive_out,
  output logic integrator_hold_out,
  output logic fault_pin_out,
  output logic fault_pin_oe_out,
  output logic irq_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // pin synchronisers; first stage read only by the second
  logic [7:0] ol_m_q, ol_s_q, sg_m_q, sg_s_q;
  logic ov_m_q, ov_s_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ol_m_q <= 8'h00;
      ol_s_q <= 8'h00;
      sg_m_q <= 8'h00;
      sg_s_q <= 8'h00;
      ov_m_q <= 1'b0;
      ov_s_q <= 1'b0;
    end else begin
      ol_m_q <= open_load_raw_in;
      ol_s_q <= ol_m_q;
      sg_m_q <= ground_short_raw_in;
      sg_s_q <= sg_m_q;
      ov_m_q <= battery_sense_in;
      ov_s_q <= ov_m_q;
    end
  end

  // register state
  logic [4:0] cfg_q, cfg_d;
  logic [3:0] stat_q, stat_d, mask_q, mask_d;
  logic [7:0] gate_q, gate_d, tested_q, tested_d, sgf_q, sgf_d, olf_q, olf_d;
  logic [7:0] pre_q, pre_d, div_m1;
  logic [3:0] exp_cnt;
  logic tick, diag_rd, fault_rd;
  logic [7:0] tt_exp, ol_filt, sg_filt, fall, rise;

  // predivider shared by all channel timers
  always_comb begin
    case (cfg_q[off_diag_pkg::CFG_TB_LSB +: 2])
      off_diag_pkg::TB_192: div_m1 = off_diag_pkg::DIV_192_M1;
      off_diag_pkg::TB_256: div_m1 = off_diag_pkg::DIV_256_M1;
      default: div_m1 = off_diag_pkg::DIV_128_M1;
    endcase
    exp_cnt = (cfg_q[off_diag_pkg::CFG_TB_LSB +: 2] == off_diag_pkg::TB_FAST) ?
      off_diag_pkg::EXP_SHORT : off_diag_pkg::EXP_LONG;
    tick = (pre_q >= div_m1);
    pre_d = tick ? 8'h00 : pre_q + 8'h01;
    gate_d = gate_cmd_in & {8{~ov_s_q}};
  end
  assign fall = gate_q & ~gate_d;
  assign rise = ~gate_q & gate_d;
  // integrator holds its value; conversion and filters are untouched
  assign integrator_hold_out = ov_s_q;
  assign gate_drive_out = gate_q;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_ch
      logic [3:0] tt_q, tt_d, olt_q, olt_d, sgt_q, sgt_d;
      always_comb begin
        tt_d = tt_q;
        if (fall[i] || rise[i] || diag_rd || fault_rd) begin
          tt_d = 4'h0;
        end else if (!gate_q[i] && tick && tt_q < exp_cnt) begin
          tt_d = tt_q + 4'h1;
        end
        olt_d = olt_q;
        if (fall[i] || rise[i] || fault_rd || !ol_s_q[i] || gate_q[i]) begin
          olt_d = 4'h0;
        end else if (tick && olt_q < exp_cnt) begin
          olt_d = olt_q + 4'h1;
        end
        sgt_d = sgt_q;
        if (fall[i] || rise[i] || fault_rd || !sg_s_q[i] || gate_q[i]) begin
          sgt_d = 4'h0;
        end else if (tick && sgt_q < exp_cnt) begin
          sgt_d = sgt_q + 4'h1;
        end
      end
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          tt_q <= 4'h0;
          olt_q <= 4'h0;
          sgt_q <= 4'h0;
        end else begin
          tt_q <= tt_d;
          olt_q <= olt_d;
          sgt_q <= sgt_d;
        end
      end
      // raw low drops the filtered level; a timebase change never wraps a held timer
      assign tt_exp[i] = !gate_q[i] && (tt_q >= exp_cnt);
      assign ol_filt[i] = ol_s_q[i] && !gate_q[i] && (olt_q >= exp_cnt);
      assign sg_filt[i] = sg_s_q[i] && !gate_q[i] && (sgt_q >= exp_cnt);
    end
  endgenerate

  // only a new set survives a read; a standing expiry is cleared with its timer
  logic [7:0] sg_set, ol_set;
  always_comb begin
    sg_set = sg_filt & tt_exp & ~sgf_q;
    ol_set = ol_filt & ~sg_filt & ~olf_q;
    tested_d = (fault_rd ? 8'h00 : tested_q) | (tt_exp & ~tested_q);
    sgf_d = (fault_rd ? 8'h00 : sgf_q) | sg_set;
    olf_d = (fault_rd ? 8'h00 : olf_q) | ol_set;
  end

  // fault pin pulls low while any unmasked fault is latched
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe_out = (|sgf_q && !cfg_q[off_diag_pkg::CFG_MASK_SG_BIT]) ||
    (|olf_q && !cfg_q[off_diag_pkg::CFG_MASK_OL_BIT]) ||
    (stat_q[off_diag_pkg::IRQ_OV_BIT] && !cfg_q[off_diag_pkg::CFG_MASK_OV_BIT]);
  assign irq_out = |(stat_q & mask_q);

  // AXI4-Lite slave; address and data latched separately, write one cycle later
  logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_fire, ar_hs;
  logic [7:0] ra, wa, ev;
  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready = !w_got_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign ar_hs = s_axi_arvalid && !rvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign ra = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
  assign wa = 8'({awaddr_q[ADDR_W-1:2], 2'b00});
  assign diag_rd = ar_hs && ra == off_diag_pkg::DIAG_OFS;
  assign fault_rd = ar_hs && ra == off_diag_pkg::FAULT_OFS;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    cfg_d = cfg_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (s_axi_awvalid && !aw_got_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = off_diag_pkg::RESP_OKAY;
      case (wa)
        off_diag_pkg::CFG_OFS: if (wstrb_q[0]) cfg_d = wdata_q[4:0];
        off_diag_pkg::IRQ_MASK_OFS: if (wstrb_q[0]) mask_d = wdata_q[3:0];
        off_diag_pkg::IRQ_STAT_OFS: if (wstrb_q[0]) stat_d = stat_q & ~wdata_q[3:0];
        off_diag_pkg::DIAG_OFS, off_diag_pkg::FAULT_OFS: bresp_d = off_diag_pkg::RESP_OKAY;
        default: bresp_d = off_diag_pkg::RESP_DECERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d = off_diag_pkg::RESP_OKAY;
      case (ra)
        off_diag_pkg::CFG_OFS: rdata_d = {27'h000_0000, cfg_q};
        off_diag_pkg::DIAG_OFS: rdata_d = {8'h00, ol_filt, sg_filt, tested_q};
        off_diag_pkg::FAULT_OFS: rdata_d = {8'h00, olf_q, sgf_q, tested_q};
        off_diag_pkg::IRQ_STAT_OFS: rdata_d = {28'h000_0000, stat_q};
        off_diag_pkg::IRQ_MASK_OFS: rdata_d = {28'h000_0000, mask_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = off_diag_pkg::RESP_DECERR;
        end
      endcase
    end
    // events set after the clear so a same-cycle event wins
    ev = 8'h00;
    ev[off_diag_pkg::IRQ_OV_BIT] = ov_s_q;
    ev[off_diag_pkg::IRQ_SG_BIT] = |(sg_set & ~sgf_q);
    ev[off_diag_pkg::IRQ_OL_BIT] = |(ol_set & ~olf_q);
    ev[off_diag_pkg::IRQ_TESTED_BIT] = |(tt_exp & ~tested_q);
    stat_d = stat_d | ev[3:0];
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      cfg_q <= off_diag_pkg::CFG_RST;
      mask_q <= off_diag_pkg::IRQ_RST;
      stat_q <= off_diag_pkg::IRQ_RST;
      gate_q <= 8'h00;
      pre_q <= 8'h00;
      tested_q <= 8'h00;
      sgf_q <= 8'h00;
      olf_q <= 8'h00;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      gate_q <= gate_d;
      pre_q <= pre_d;
      tested_q <= tested_d;
      sgf_q <= sgf_d;
      olf_q <= olf_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_fault_read;
    fault_rd && !sg_set[0] && !ol_set[0] && !(tt_exp[0] && !tested_q[0]);
  endsequence
  sequence s_ov_seen;
    ov_s_q [*2];
  endsequence

  a_gate_ov_low: assert property (ov_s_q |=> gate_drive_out == 8'h00)
    else $error("gate driven during overvoltage");
  a_ov_flag_set: assert property (s_ov_seen |-> stat_q[off_diag_pkg::IRQ_OV_BIT])
    else $error("overvoltage flag not set");
  a_integ_hold: assert property (integrator_hold_out == ov_s_q)
    else $error("integrator hold not tied to overvoltage");
  a_ol_drop_now: assert property (!ol_s_q[0] |-> !ol_filt[0] ##1 g_ch[0].olt_q == 4'h0)
    else $error("filtered open-load not dropped");
  a_sg_drop_now: assert property (!sg_s_q[0] |-> !sg_filt[0] ##1 g_ch[0].sgt_q == 4'h0)
    else $error("filtered short not dropped or timer kept");
  a_tested_set: assert property (tt_exp[0] && !fault_rd |=> tested_q[0])
    else $error("tested flag missed timer expiry");
  a_fault_clears: assert property (s_fault_read |=> !sgf_q[0] && !olf_q[0] && !tested_q[0] &&
    g_ch[0].tt_q == 4'h0)
    else $error("fault read did not clear flags");
  a_fall_clears: assert property ($fell(gate_drive_out[0]) |-> g_ch[0].olt_q == 4'h0 &&
    g_ch[0].sgt_q == 4'h0 && g_ch[0].tt_q == 4'h0)
    else $error("falling gate did not clear timers");
  a_rise_clears: assert property ($rose(gate_drive_out[0]) |-> g_ch[0].tt_q == 4'h0)
    else $error("rising gate did not clear tested timer");
  a_sg_fault_set: assert property (sg_filt[0] && tt_exp[0] && !fault_rd |=> sgf_q[0])
    else $error("short fault not latched");
  a_ol_fault_set: assert property (ol_filt[0] && !sg_filt[0] && !fault_rd |=> olf_q[0])
    else $error("open-load fault not latched");
  a_fault_pin: assert property (sgf_q[0] && !cfg_q[off_diag_pkg::CFG_MASK_SG_BIT]
    |-> fault_pin_oe_out)
    else $error("fault pin not driven");
endmodule
`default_nettype wire

// >>> tb/host_model.sv
/*
  AXI4-Lite host model: one write task and one read task.
  Assumes the slave shares clk_in and that the bench watchdog ends any hang.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      // released payload flips so a stale value is never mistaken for live
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~v;
      end
      if (bvalid === 1'b1) begin
        done = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_in);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid === 1'b1) begin
        done = 1'b1;
        v = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/off_state_diag_tb.sv
/*
  Bench for the off-state diagnostic block: register traffic via host_model,
  comparator, gate and battery stimulus driven on the rising edge.
  Assumes 50 MHz clk_in and the design's own 2-flop input synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module off_state_diag_tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] gate_cmd = 8'h00, ol_raw = 8'h00, sg_raw = 8'h00, gate_drive, awaddr, araddr;
  logic bat_hi = 1'b0, hold, pin, pin_oe, irq;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int fail_count = 0;
  int checks = 0;
  logic [1:0] tb_sel [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
  int div_n [4] = '{128, 192, 128, 256};
  int lo_n [4] = '{10, 10, 2, 10};
  always #10 clk_in = ~clk_in;
  off_state_diag off_state_diag_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .gate_cmd_in(gate_cmd), .open_load_raw_in(ol_raw), .ground_short_raw_in(sg_raw),
    .battery_sense_in(bat_hi), .gate_drive_out(gate_drive), .integrator_hold_out(hold),
    .fault_pin_out(pin), .fault_pin_oe_out(pin_oe), .irq_out(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  host_model host_model_inst (.clk_in, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host_model_inst.wr(a, v, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host_model_inst.rd(a, d, r);
    chk(d, e);
  endtask
  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    // longest path: three timebase passes of about 11 periods and one of 3, plus fixed waits
    cyc(40000);
    fail_count++;
    test_done();
  end
  initial begin
    cyc(12);
    rst_b_in <= 1'b1;
    rd_chk(off_diag_pkg::CFG_OFS, 32'h0000_0000);
    rd_chk(off_diag_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, off_diag_pkg::RESP_DECERR});
    wr(8'h40, 32'h0000_00FF);
    chk({30'h0, r}, {30'h0, off_diag_pkg::RESP_DECERR});
    wr(off_diag_pkg::CFG_OFS, 32'h0000_0002);
    cyc(450);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_00FF);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_0000);
    // diag read restarts the timer: past 3 ticks since clear, under 2 since restart
    cyc(140);
    rd_chk(off_diag_pkg::DIAG_OFS, 32'h0000_0000);
    cyc(245);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_0000);
    cyc(450);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_00FF);
    ol_raw <= 8'h05;
    sg_raw <= 8'h06;
    cyc(450);
    #1;
    chk({30'h0, pin_oe, pin}, 32'h0000_0002);
    rd_chk(off_diag_pkg::DIAG_OFS, 32'h0005_06FF);
    rd_chk(off_diag_pkg::IRQ_STAT_OFS, 32'h0000_000E);
    wr(off_diag_pkg::IRQ_MASK_OFS, 32'h0000_0002);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0001_06FF);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_0000);
    wr(off_diag_pkg::IRQ_STAT_OFS, 32'h0000_0002);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    wr(off_diag_pkg::CFG_OFS, 32'h0000_000E);
    cyc(450);
    #1;
    chk({31'h0, pin_oe}, 32'h0000_0000);
    wr(off_diag_pkg::CFG_OFS, 32'h0000_0002);
    ol_raw <= 8'h00;
    cyc(4);
    rd_chk(off_diag_pkg::DIAG_OFS, 32'h0000_06FF);
    sg_raw <= 8'h00;
    cyc(4);
    rd_chk(off_diag_pkg::DIAG_OFS, 32'h0000_00FF);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0001_06FF);
    gate_cmd <= 8'hFF;
    cyc(450);
    #1;
    chk({24'h0, gate_drive}, 32'h0000_00FF);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_0000);
    gate_cmd <= 8'h00;
    cyc(200);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_0000);
    cyc(450);
    rd_chk(off_diag_pkg::FAULT_OFS, 32'h0000_00FF);
    gate_cmd <= 8'hFF;
    bat_hi <= 1'b1;
    cyc(5);
    #1;
    chk({22'h0, pin_oe, hold, gate_drive}, 32'h0000_0300);
    host_model_inst.rd(off_diag_pkg::IRQ_STAT_OFS, d, r);
    chk({31'h0, d[0]}, 32'h0000_0001);
    bat_hi <= 1'b0;
    cyc(5);
    #1;
    chk({23'h0, hold, gate_drive}, 32'h0000_00FF);
    wr(off_diag_pkg::IRQ_STAT_OFS, 32'h0000_000F);
    rd_chk(off_diag_pkg::IRQ_STAT_OFS, 32'h0000_0000);
    gate_cmd <= 8'h00;
    // tested event watched on irq alone, since a diag or fault read would restart the timer
    for (int i = 0; i < 4; i++) begin
      wr(off_diag_pkg::CFG_OFS, {30'h0, tb_sel[i]});
      host_model_inst.rd(off_diag_pkg::FAULT_OFS, d, r);
      wr(off_diag_pkg::IRQ_STAT_OFS, 32'h0000_000F);
      wr(off_diag_pkg::IRQ_MASK_OFS, 32'h0000_0008);
      cyc(lo_n[i] * div_n[i] - 30);
      #1;
      chk({31'h0, irq}, 32'h0000_0000);
      cyc(div_n[i] + 60);
      #1;
      chk({31'h0, irq}, 32'h0000_0001);
    end
    test_done();
  end
endmodule
`default_nettype wire
